// ==== rtl/questionable_status_reporting.sv ====
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: Top register 16 bits, bit 15 reads zero.
// R2: Bit 0 reports overvoltage protection trip.
// R3: Bit 1 reports overcurrent protection trip.
// R4: Bit 2 reports mains fault or interruption.
// R5: Bit 4 reports overheat protection trip.
// R6: Bit 8 watchdog trip, multi-channel only.
// R7: Bit 11 synchronized shutdown, multi-channel only.
// R8: Bit 13 carries instrument subregister summary.
// R9: Event read returns value then clears.
// R10: Condition read returns live bits, no clear.
// R11: Top enable mask read/write, full 16 bits.
// R12: Top falling filter selects one-to-zero latching.
// R13: Top rising filter selects zero-to-one latching.
// R14: Instrument subregister bits 0-3 channels, rest zero.
// R15: Channel bit mirrors that channel's summary.
// R16: Instrument event read clears, condition read not.
// R17: Instrument has own enable and both filters.
// R18: Each channel register feeds its instrument bit.
// R19: Host selects channel by number in path.
// R20: Channel registers share the top bit layout.
// R21: Preset restores enable and filter defaults.
// R22: Enabled transitions latch event until read/clear.
// R23: Summary is OR of event AND enable.
module questionable_status_reporting (
    input  wire logic                      CLK_SYS,
    input  wire logic                      RST,
    input  wire logic                      MULTI_MODEL,
    input  wire ques_pkg::flag_s           TOP_FLAGS,
    input  wire ques_pkg::flag_s [3:0]     CH_FLAGS,
    input  wire logic                      CMD_VALID,
    input  wire ques_pkg::cmd_s            CMD,
    output logic                           RSP_VALID,
    output ques_pkg::rsp_s                 RSP,
    output logic                           QUES_SUMMARY
);

    localparam int NU = ques_pkg::NUM_UNITS;

    logic [15:0] live_state_query_now  [NU];
    logic [15:0] live_state_query_q    [NU];
    logic [15:0] event_q   [NU];
    logic [15:0] enable_q  [NU];
    logic [15:0] rise_q    [NU];
    logic [15:0] fall_q    [NU];
    logic [15:0] rise_hit  [NU];
    logic [15:0] fall_hit  [NU];
    logic [NU-1:0] sum_q;
    logic [NU-1:0] hit;
    logic [NU-1:0] ev_clr;
    logic          target_ok;
    logic          is_global;
    logic [15:0]   top_mask;
    logic          rsp_valid_q;
    ques_pkg::rsp_s rsp_q;

    function automatic logic [15:0] pack_flags(input ques_pkg::flag_s f,
                                               input logic summary,
                                               input logic [15:0] mask);
        logic [15:0] v;
        v = 16'h0000;
        v[ques_pkg::BIT_HIGH_VOLT]  = f.high_voltage_trip;
        v[ques_pkg::BIT_EXCESS_CUR] = f.excess_current_trip;
        v[ques_pkg::BIT_MAINS_LOSS] = f.mains_loss_flag;
        v[ques_pkg::BIT_OVERHEAT]   = f.overheat_flag;
        v[ques_pkg::BIT_LINK_MON]   = f.link_monitor_trip;
        v[ques_pkg::BIT_SYNC_TRIP]  = f.channel_sync_trip;
        v[ques_pkg::BIT_SUMMARY]    = summary;
        return v & mask;
    endfunction

    // Single-output parts have no watchdog, sync or summary bits at all.
    assign top_mask = MULTI_MODEL ? ques_pkg::MASK_MULTI
                                  : ques_pkg::MASK_SINGLE;

    // Live condition of every unit; unassigned bits are masked to zero.
    always_comb begin
        live_state_query_now[ques_pkg::UNIT_TOP] =
            pack_flags(TOP_FLAGS, sum_q[ques_pkg::UNIT_GATHER],
                       top_mask); // see R1 R2 R3 R4 R5 R6 R7 R8
        live_state_query_now[ques_pkg::UNIT_GATHER] =
            {12'h000, sum_q[NU-1:ques_pkg::UNIT_CH0]}
            & (MULTI_MODEL ? ques_pkg::MASK_GATHER
                           : 16'h0000); // see R14 R15 R18
        for (int i = 0; i < ques_pkg::NUM_CH; i++) begin
            // A channel register has nothing beneath it, so its summary
            // position stays low.
            live_state_query_now[ques_pkg::UNIT_CH0 + i] =
                pack_flags(CH_FLAGS[i], 1'b0,
                           MULTI_MODEL ? ques_pkg::MASK_MULTI
                                       : 16'h0000); // see R20
        end
    end

    // Command decode: global commands ignore the target field.
    assign is_global = (CMD.op == ques_pkg::OP_PRESET)
                     || (CMD.op == ques_pkg::OP_CLEAR);
    assign target_ok = (CMD.target < 3'(NU))
                     && ((CMD.target == 3'(ques_pkg::UNIT_TOP))
                         || MULTI_MODEL); // see R19

    always_comb begin
        for (int u = 0; u < NU; u++) begin
            hit[u] = CMD_VALID && !is_global && target_ok
                     && (CMD.target == 3'(u));
            ev_clr[u] = (hit[u] && (CMD.op == ques_pkg::OP_READ_EVENT))
                      || (CMD_VALID && (CMD.op == ques_pkg::OP_CLEAR));
            rise_hit[u] = live_state_query_now[u] & ~live_state_query_q[u] & rise_q[u]; // see R13
            fall_hit[u] = ~live_state_query_now[u] & live_state_query_q[u] & fall_q[u]; // see R12
        end
    end

    // Previous condition, the reference for edge detection. Clearing it
    // at reset means a fault already present at start-up counts as a rise.
    always_ff @(posedge CLK_SYS) begin
        for (int u = 0; u < NU; u++) begin
            if (RST) begin
                live_state_query_q[u] <= ques_pkg::RST_LIVE_STATE_QUERY;
            end else begin
                live_state_query_q[u] <= live_state_query_now[u];
            end
        end
    end

    // Event latches; a new edge in the clearing cycle survives the clear.
    always_ff @(posedge CLK_SYS) begin
        for (int u = 0; u < NU; u++) begin
            if (RST) begin
                event_q[u] <= ques_pkg::RST_EVENT;
            end else begin
                event_q[u] <= (ev_clr[u] ? 16'h0000 : event_q[u])
                              | rise_hit[u] | fall_hit[u]; // see R9 R16 R22
            end
        end
    end

    // Enable masks and transition filters.
    always_ff @(posedge CLK_SYS) begin
        for (int u = 0; u < NU; u++) begin
            if (RST || (CMD_VALID && (CMD.op == ques_pkg::OP_PRESET))) begin
                enable_q[u] <= (u >= ques_pkg::UNIT_CH0)
                               ? ques_pkg::RST_CH_ENABLE
                               : ques_pkg::RST_ENABLE; // see R21
                rise_q[u]   <= ques_pkg::RST_RISE;
                fall_q[u]   <= ques_pkg::RST_FALL;
            end else if (hit[u]) begin
                case (CMD.op)
                    ques_pkg::OP_WRITE_ENABLE: begin
                        enable_q[u] <= CMD.data; // see R11 R17
                    end
                    ques_pkg::OP_WRITE_FALL: begin
                        fall_q[u] <= CMD.data; // see R12 R17
                    end
                    ques_pkg::OP_WRITE_RISE: begin
                        rise_q[u] <= CMD.data; // see R13 R17
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Summaries, one cycle behind the event and mask they are built from.
    always_ff @(posedge CLK_SYS) begin
        for (int u = 0; u < NU; u++) begin
            if (RST) begin
                sum_q[u] <= 1'b0;
            end else begin
                sum_q[u] <= |(event_q[u] & enable_q[u]); // see R23
            end
        end
    end

    // Answer one cycle after each command; event reads return the value
    // held before the clear of the same cycle.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end else begin
            rsp_valid_q <= CMD_VALID;
            rsp_q.err   <= CMD_VALID && !is_global && !target_ok;
            rsp_q.data  <= 16'h0000;
            if (CMD_VALID && !is_global && target_ok) begin
                case (CMD.op)
                    ques_pkg::OP_READ_EVENT: begin
                        rsp_q.data <= event_q[CMD.target]; // see R9 R16
                    end
                    ques_pkg::OP_READ_LIVE_STATE_QUERY: begin
                        rsp_q.data <= live_state_query_now[CMD.target]; // see R10 R16
                    end
                    ques_pkg::OP_READ_ENABLE: begin
                        rsp_q.data <= enable_q[CMD.target]; // see R11
                    end
                    ques_pkg::OP_READ_FALL: begin
                        rsp_q.data <= fall_q[CMD.target]; // see R12
                    end
                    ques_pkg::OP_READ_RISE: begin
                        rsp_q.data <= rise_q[CMD.target]; // see R13
                    end
                    default: begin
                        rsp_q.data <= 16'h0000;
                    end
                endcase
            end
        end
    end

    assign RSP_VALID    = rsp_valid_q;
    assign RSP          = rsp_q;
    assign QUES_SUMMARY = sum_q[ques_pkg::UNIT_TOP];

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    chk_top_bit15_low: assert property ( // see R1
        !event_q[0][ques_pkg::BIT_UNUSED_TOP]
        && !live_state_query_q[0][ques_pkg::BIT_UNUSED_TOP])
        else $error("top bit 15 not zero");

    chk_overvolt_bit: assert property ( // see R2
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_HIGH_VOLT]
            == $past(TOP_FLAGS.high_voltage_trip)))
        else $error("overvoltage bit wrong");

    chk_overcur_bit: assert property ( // see R3
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_EXCESS_CUR]
            == $past(TOP_FLAGS.excess_current_trip)))
        else $error("overcurrent bit wrong");

    chk_mains_bit: assert property ( // see R4
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_MAINS_LOSS]
            == $past(TOP_FLAGS.mains_loss_flag)))
        else $error("mains loss bit wrong");

    chk_overheat_bit: assert property ( // see R5
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_OVERHEAT]
            == $past(TOP_FLAGS.overheat_flag)))
        else $error("overheat bit wrong");

    chk_watchdog_bit: assert property ( // see R6
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_LINK_MON]
            == ($past(TOP_FLAGS.link_monitor_trip) && $past(MULTI_MODEL))))
        else $error("watchdog bit wrong");

    chk_sync_bit: assert property ( // see R7
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_SYNC_TRIP]
            == ($past(TOP_FLAGS.channel_sync_trip) && $past(MULTI_MODEL))))
        else $error("sync trip bit wrong");

    chk_top_summary_link: assert property ( // see R8
        !RST |=> (live_state_query_q[0][ques_pkg::BIT_SUMMARY]
            == ($past(sum_q[1]) && $past(MULTI_MODEL))))
        else $error("top bit 13 does not follow instrument summary");

    chk_event_read_clear: assert property ( // see R9
        ev_clr[0] |=> (event_q[0] == $past(rise_hit[0] | fall_hit[0])))
        else $error("event read did not clear top event");

    chk_live_state_query_read_keeps: assert property ( // see R10
        (hit[0] && CMD.op == ques_pkg::OP_READ_LIVE_STATE_QUERY
         && rise_hit[0] == 16'h0000 && fall_hit[0] == 16'h0000)
        |=> $stable(event_q[0]))
        else $error("condition read altered the event register");

    chk_enable_write: assert property ( // see R11
        (hit[0] && CMD.op == ques_pkg::OP_WRITE_ENABLE)
        |=> (enable_q[0] == $past(CMD.data)))
        else $error("enable write lost");

    chk_fall_latch: assert property ( // see R12
        (fall_hit[0] != 16'h0000)
        |=> ((event_q[0] & $past(fall_hit[0])) == $past(fall_hit[0])))
        else $error("falling edge not latched");

    chk_rise_latch: assert property ( // see R13
        (rise_hit[0] != 16'h0000)
        |=> ((event_q[0] & $past(rise_hit[0])) == $past(rise_hit[0])))
        else $error("rising edge not latched");

    chk_gather_upper_low: assert property ( // see R14
        (live_state_query_q[1][15:4] == 12'h000) && (event_q[1][15:4] == 12'h000))
        else $error("instrument upper bits not zero");

    chk_gather_mirrors: assert property ( // see R15 R18
        !RST |=> (live_state_query_now[1][3:0]
                  == ({$past(|(event_q[5] & enable_q[5])),
                       $past(|(event_q[4] & enable_q[4])),
                       $past(|(event_q[3] & enable_q[3])),
                       $past(|(event_q[2] & enable_q[2]))}
                      & {4{MULTI_MODEL}})))
        else $error("instrument bit does not follow channel summary");

    chk_gather_read_clear: assert property ( // see R16
        ev_clr[1] |=> (event_q[1] == $past(rise_hit[1] | fall_hit[1])))
        else $error("instrument event read did not clear");

    chk_gather_filter_wr: assert property ( // see R17
        (hit[1] && CMD.op == ques_pkg::OP_WRITE_RISE)
        |=> (rise_q[1] == $past(CMD.data)))
        else $error("instrument rising filter write lost");

    chk_channel_layout: assert property ( // see R20
        !RST |=> (live_state_query_q[2][ques_pkg::BIT_HIGH_VOLT]
            == ($past(CH_FLAGS[0].high_voltage_trip) && $past(MULTI_MODEL))))
        else $error("channel layout wrong");

    chk_preset_values: assert property ( // see R21
        (CMD_VALID && CMD.op == ques_pkg::OP_PRESET)
        |=> (enable_q[0] == ques_pkg::RST_ENABLE
             && enable_q[2] == ques_pkg::RST_CH_ENABLE
             && rise_q[1] == ques_pkg::RST_RISE
             && fall_q[5] == ques_pkg::RST_FALL))
        else $error("preset defaults wrong");

    chk_event_sticky: assert property ( // see R22
        (event_q[0] != 16'h0000 && !ev_clr[0])
        |=> ((event_q[0] & $past(event_q[0])) == $past(event_q[0])))
        else $error("event bit dropped without clear");

    chk_summary_or: assert property ( // see R23
        !RST |=> ((sum_q[0] == $past(|(event_q[0] & enable_q[0])))
                  && (sum_q[2] == $past(|(event_q[2] & enable_q[2])))
                  && (QUES_SUMMARY == sum_q[0])))
        else $error("summary not or of enabled events");

    chk_event_read_value: assert property ( // see R9
        (hit[0] && CMD.op == ques_pkg::OP_READ_EVENT)
        |=> (RSP.data == $past(event_q[0])))
        else $error("event read returned wrong value");

    chk_live_state_query_read_value: assert property ( // see R10
        (hit[0] && CMD.op == ques_pkg::OP_READ_LIVE_STATE_QUERY)
        |=> (RSP.data == live_state_query_q[0]))
        else $error("condition read returned wrong value");

    chk_top_fall_wr: assert property ( // see R12
        (hit[0] && CMD.op == ques_pkg::OP_WRITE_FALL)
        |=> (fall_q[0] == $past(CMD.data)))
        else $error("top falling filter write lost");

    chk_gather_fall_wr: assert property ( // see R17
        (hit[1] && CMD.op == ques_pkg::OP_WRITE_FALL)
        |=> (fall_q[1] == $past(CMD.data)))
        else $error("instrument falling filter write lost");

    chk_chan_sync_bit: assert property ( // see R20
        !RST |=> (live_state_query_q[5][ques_pkg::BIT_SYNC_TRIP]
                  == ($past(CH_FLAGS[3].channel_sync_trip)
                      && $past(MULTI_MODEL))))
        else $error("channel sync bit in wrong place");

    chk_single_units_low: assert property ( // see R6 R7 R14
        !MULTI_MODEL |-> (live_state_query_now[1] == 16'h0000
                          && live_state_query_now[ques_pkg::UNIT_CH0] == 16'h0000
                          && live_state_query_now[0][ques_pkg::BIT_SUMMARY] == 1'b0))
        else $error("single output model shows multi-channel bits");

    chk_refused_target: assert property (
        (CMD_VALID && !is_global && !target_ok)
        |=> (RSP.err && RSP.data == 16'h0000))
        else $error("refused command not flagged");

    chk_answer_next: assert property (
        CMD_VALID |=> RSP_VALID)
        else $error("command not answered");

    cov_event_read: cover property (
        (event_q[0] != 16'h0000) ##1 ev_clr[0] ##1 RSP_VALID);
    cov_chain_up: cover property (
        (rise_hit[2] != 16'h0000) ##[1:6] sum_q[0]);
    cov_preset: cover property (
        CMD_VALID && CMD.op == ques_pkg::OP_PRESET);
    cov_bad_target: cover property (RSP_VALID && RSP.err);

endmodule // questionable_status_reporting
`default_nettype wire

// ==== rtl/ques_pkg.sv ====
package ques_pkg;

    localparam int NUM_CH      = 4;
    localparam int NUM_UNITS   = 6;
    localparam int UNIT_TOP    = 0;
    localparam int UNIT_GATHER = 1;
    localparam int UNIT_CH0    = 2;

    // Bit positions shared by the top level and every channel register.
    localparam int BIT_HIGH_VOLT  = 0;
    localparam int BIT_EXCESS_CUR = 1;
    localparam int BIT_MAINS_LOSS = 2;
    localparam int BIT_OVERHEAT   = 4;
    localparam int BIT_LINK_MON   = 8;
    localparam int BIT_SYNC_TRIP  = 11;
    localparam int BIT_SUMMARY    = 13;
    localparam int BIT_UNUSED_TOP = 15;

    localparam logic [15:0] MASK_MULTI  = 16'h2917;
    localparam logic [15:0] MASK_SINGLE = 16'h0017;
    localparam logic [15:0] MASK_GATHER = 16'h000f;

    localparam logic [15:0] RST_ENABLE    = 16'h0000;
    localparam logic [15:0] RST_CH_ENABLE = 16'h7fff;
    localparam logic [15:0] RST_RISE      = 16'h7fff;
    localparam logic [15:0] RST_FALL      = 16'h0000;
    localparam logic [15:0] RST_EVENT     = 16'h0000;
    localparam logic [15:0] RST_LIVE_STATE_QUERY      = 16'h0000;

    typedef enum logic [3:0] {
        OP_READ_EVENT,
        OP_READ_LIVE_STATE_QUERY,
        OP_WRITE_ENABLE,
        OP_READ_ENABLE,
        OP_WRITE_FALL,
        OP_READ_FALL,
        OP_WRITE_RISE,
        OP_READ_RISE,
        OP_PRESET,
        OP_CLEAR
    } op_e;

    typedef struct packed {
        op_e         op;
        logic [2:0]  target;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic        err;
        logic [15:0] data;
    } rsp_s;

    typedef struct packed {
        logic high_voltage_trip;
        logic excess_current_trip;
        logic mains_loss_flag;
        logic overheat_flag;
        logic link_monitor_trip;
        logic channel_sync_trip;
    } flag_s;

endpackage

// ==== tb/ques_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module ques_host (
    input  wire logic           clk_sys,
    output var  logic           cmd_valid,
    output var  ques_pkg::cmd_s cmd,
    input  wire logic           rsp_valid,
    input  wire ques_pkg::rsp_s rsp
);
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // The answer stands for the one cycle after the edge that takes the
    // command, so it is read just after that edge, once it has settled.
    task automatic send(input ques_pkg::op_e op, input logic [2:0] tgt,
                        input logic [15:0] d, output ques_pkg::rsp_s r,
                        output bit ok);
        ok = 1'b0;
        r  = '0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd       <= '{op: op, target: tgt, data: d};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd.data  <= ~d;
        #1;
        if (rsp_valid === 1'b1) begin
            ok = 1'b1;
            r  = rsp;
        end
    endtask
endmodule // ques_host
`default_nettype wire

// ==== tb/questionable_status_reporting_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end end
module questionable_status_reporting_test;
    logic                     clk_sys = 1'b0;
    logic                     rst = 1'b1;
    logic                     multi_model = 1'b1;
    ques_pkg::flag_s          top_flags = '0;
    ques_pkg::flag_s [3:0]    ch_flags = '0;
    logic                     cmd_valid;
    ques_pkg::cmd_s           cmd;
    logic                     rsp_valid;
    ques_pkg::rsp_s           rsp;
    logic                     ques_summary;
    int                       miscompares = 0;
    int                       total_checks = 0;
    logic [31:0]              rnd_state = 32'h0000c14a;
    logic [15:0]              en[6], rise[6], fall[6], ev[6], cnd[6];
    logic                     sm[6];

    always #4 clk_sys = ~clk_sys;

    questionable_status_reporting u_questionable_status_reporting (
        .CLK_SYS(clk_sys), .RST(rst), .MULTI_MODEL(multi_model),
        .TOP_FLAGS(top_flags), .CH_FLAGS(ch_flags), .CMD_VALID(cmd_valid),
        .CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp),
        .QUES_SUMMARY(ques_summary));

    ques_host u_ques_host (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp));

    function logic [31:0] next_rnd();
        rnd_state ^= rnd_state << 13;
        rnd_state ^= rnd_state >> 17;
        rnd_state ^= rnd_state << 5;
        return rnd_state;
    endfunction

    function automatic logic [15:0] fmap(ques_pkg::flag_s f);
        logic [15:0] v;
        v     = 16'h0000;
        v[0]  = f.high_voltage_trip;
        v[1]  = f.excess_current_trip;
        v[2]  = f.mains_loss_flag;
        v[4]  = f.overheat_flag;
        v[8]  = f.link_monitor_trip;
        v[11] = f.channel_sync_trip;
        return v;
    endfunction

    task automatic model_preset();
        for (int u = 0; u < 6; u++) begin
            en[u]   = (u >= 2) ? 16'h7fff : 16'h0000;
            rise[u] = 16'h7fff;
            fall[u] = 16'h0000;
        end
    endtask

    task automatic model_reset();
        model_preset();
        for (int u = 0; u < 6; u++) begin
            ev[u]  = 16'h0000;
            cnd[u] = 16'h0000;
            sm[u]  = 1'b0;
        end
    endtask

    task automatic upd(int u, logic [15:0] c);
        ev[u]  |= (c & ~cnd[u] & rise[u]) | (~c & cnd[u] & fall[u]);
        cnd[u] = c;
        sm[u]  = |(ev[u] & en[u]);
    endtask

    // Channels first, then the gather unit, then the top, as the chain runs.
    task automatic settle();
        logic [15:0] c;
        for (int u = 2; u < 6; u++)
            upd(u, multi_model ? fmap(ch_flags[u-2]) : 16'h0000);
        c = 16'h0000;
        for (int i = 0; i < 4; i++) c[i] = sm[2+i];
        upd(1, multi_model ? c : 16'h0000);
        c = fmap(top_flags) & (multi_model ? 16'h2917 : 16'h0017);
        c[13] = multi_model & sm[1];
        upd(0, c);
    endtask

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic exec(ques_pkg::op_e op, logic [2:0] t, logic [15:0] d);
        ques_pkg::rsp_s got;
        bit             ok;
        logic [15:0]    ex;
        logic           er;
        u_ques_host.send(op, t, d, got, ok);
        if (!ok) begin
            miscompares++;
            close_out();
        end
        er = (t >= 6 || (t != 0 && !multi_model)) &&
             op != ques_pkg::OP_PRESET && op != ques_pkg::OP_CLEAR;
        ex = 16'h0000;
        if (!er) case (op)
            ques_pkg::OP_READ_EVENT: begin
                ex    = ev[t];
                ev[t] = 16'h0000;
            end
            ques_pkg::OP_READ_LIVE_STATE_QUERY:    ex = cnd[t];
            ques_pkg::OP_WRITE_ENABLE: en[t] = d;
            ques_pkg::OP_READ_ENABLE:  ex = en[t];
            ques_pkg::OP_WRITE_FALL:   fall[t] = d;
            ques_pkg::OP_READ_FALL:    ex = fall[t];
            ques_pkg::OP_WRITE_RISE:   rise[t] = d;
            ques_pkg::OP_READ_RISE:    ex = rise[t];
            ques_pkg::OP_PRESET:       model_preset();
            ques_pkg::OP_CLEAR:
                for (int u = 0; u < 6; u++) ev[u] = 16'h0000;
            default: ;
        endcase
        `CHK("response error", er, got.err)
        `CHK("response data", ex, got.data)
        repeat (10) @(posedge clk_sys);
        settle();
        `CHK("top summary", sm[0], ques_summary)
    endtask

    task automatic read_filters();
        for (int u = 0; u < 6; u++) begin
            exec(ques_pkg::OP_READ_ENABLE, 3'(u), 16'h0000);
            exec(ques_pkg::OP_READ_RISE, 3'(u), 16'h0000);
            exec(ques_pkg::OP_READ_FALL, 3'(u), 16'h0000);
        end
    endtask

    task automatic shake_flags();
        logic [31:0] r;
        r = next_rnd();
        top_flags <= r[5:0];
        ch_flags  <= r[29:6];
        repeat (10) @(posedge clk_sys);
        settle();
    endtask

    initial begin
        logic [31:0] r;
        model_reset();
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        read_filters();
        exec(ques_pkg::OP_WRITE_ENABLE, 3'h0, 16'hffff);
        exec(ques_pkg::OP_READ_ENABLE, 3'h0, 16'h0000);
        for (int it = 0; it < 300; it++) begin
            r = next_rnd();
            if (r[0]) shake_flags();
            r = next_rnd();
            exec(ques_pkg::op_e'({1'b0, r[2:0]}), r[6:4], r[31:16]);
        end
        exec(ques_pkg::OP_PRESET, 3'h3, 16'h0000);
        read_filters();
        shake_flags();
        exec(ques_pkg::OP_CLEAR, 3'h6, 16'h0000);
        for (int u = 0; u < 6; u++)
            exec(ques_pkg::OP_READ_EVENT, 3'(u), 16'h0000);
        rst         <= 1'b1;
        multi_model <= 1'b0;
        repeat (6) @(posedge clk_sys);
        model_reset();
        rst <= 1'b0;
        exec(ques_pkg::OP_WRITE_ENABLE, 3'h0, 16'hffff);
        for (int it = 0; it < 40; it++) begin
            shake_flags();
            r = next_rnd();
            exec(r[0] ? ques_pkg::OP_READ_LIVE_STATE_QUERY : ques_pkg::OP_READ_EVENT,
                 {2'b00, r[1]}, 16'h0000);
        end
        close_out();
    end
endmodule // questionable_status_reporting_test
`default_nettype wire
